// ==== src/cec_defs.svh ====
// register offsets, field positions and reset values of the comparator control bank
// assumes: included by the package and the design file by bare name
`ifndef CEC_DEFS_SVH
`define CEC_DEFS_SVH

`define CEC_CTRL_ADDR 8'h9b
`define CEC_MODE_ADDR 8'h9d
`define CEC_CTRL_RST 8'h00
`define CEC_MODE_RST 8'h02
`define CEC_BIT_EN 7
`define CEC_BIT_OUT 6
`define CEC_BIT_RISE 5
`define CEC_BIT_FALL 4
`define CEC_HYP_HI 3
`define CEC_HYP_LO 2
`define CEC_HYN_HI 1
`define CEC_HYN_LO 0
`define CEC_MD_HI 1
`define CEC_MD_LO 0
`define CEC_SYNC_RST 1'b0
`define CEC_EN_RST 1'b0
`define CEC_FLAG_RST 1'b0
`define CEC_HYST_RST 2'h0
`define CEC_IE_RST 1'b0
`define CEC_MD_RST 2'h2

`endif

// ==== src/cec_pkg.sv ====
// types shared by the comparator control bank
// assumes: cec_defs.svh on the include path
`include "cec_defs.svh"

package cec_pkg;
    typedef logic [7:0] cec_byte_t;
    typedef logic [1:0] cec_hyst_t;
endpackage : cec_pkg

// ==== src/cec_comparator_edge_control.sv ====
// comparator control and mode registers on the special function register bus
// assumes: single-cycle sfr read/write strobes from the core, async comparator level
//
// What this block does
// (R1) control register at 0x9b on every page, all bits zero after reset
// (R2) bit 7 is read/write enable; bit 6 reads the comparator result
// (R3) bit 5 set on rising result; cleared only by software writing 0
// (R4) bit 4 set on falling result; cleared only by software writing 0
// (R5) bits 3:2 select positive hysteresis: off, 5, 10, 20 mV
// (R6) bits 1:0 select negative hysteresis: off, 5, 10, 20 mV
// (R7) mode register bits 5 and 4 enable rise and fall interrupt requests
// (R8) comparator result is synchronised by two flip-flops before use
`timescale 1ns/100ps
`default_nettype none
`include "cec_defs.svh"

module cec_comparator_edge_control
    import cec_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrRead,
    output logic [7:0] sfrRdata,
    output logic sfrSel,
    input wire logic compareResultAsync,
    output logic compareEnable,
    output logic [1:0] posHysteresisSel,
    output logic [1:0] negHysteresisSel,
    output logic [1:0] compareModeSel,
    output logic compareIrq
);

    // ----------------------------------------------------------------
    // result synchroniser and edge detect
    // ----------------------------------------------------------------
    logic syncA_q;
    logic syncB_q;
    logic resultPrev_q;
    logic syncA_d;
    logic syncB_d;
    logic resultPrev_d;
    logic riseEvent;
    logic fallEvent;

    always_comb begin
        syncA_d = compareResultAsync;
        syncB_d = syncA_q; // [R8]
        resultPrev_d = syncB_q;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= `CEC_SYNC_RST;
            syncB_q <= `CEC_SYNC_RST;
            resultPrev_q <= `CEC_SYNC_RST;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
            resultPrev_q <= resultPrev_d;
        end
    end

    assign riseEvent = syncB_q & ~resultPrev_q; // [R3]
    assign fallEvent = ~syncB_q & resultPrev_q; // [R4]

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic ctrlHit;
    logic modeHit;
    logic ctrlWrite;
    logic modeWrite;

    // both registers sit on every page, so only the address is compared
    assign ctrlHit = (sfrAddr == `CEC_CTRL_ADDR); // [R1]
    assign modeHit = (sfrAddr == `CEC_MODE_ADDR); // [R7]
    assign ctrlWrite = sfrWrite & ctrlHit;
    assign modeWrite = sfrWrite & modeHit;

    // ----------------------------------------------------------------
    // control fields: enable and hysteresis
    // ----------------------------------------------------------------
    logic enable_q;
    logic enable_d;
    cec_hyst_t posHyst_q;
    cec_hyst_t posHyst_d;
    cec_hyst_t negHyst_q;
    cec_hyst_t negHyst_d;

    always_comb begin
        enable_d = enable_q;
        posHyst_d = posHyst_q;
        negHyst_d = negHyst_q;
        if (ctrlWrite) begin
            enable_d = sfrWdata[`CEC_BIT_EN]; // [R2]
            posHyst_d = sfrWdata[`CEC_HYP_HI:`CEC_HYP_LO]; // [R5]
            negHyst_d = sfrWdata[`CEC_HYN_HI:`CEC_HYN_LO]; // [R6]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= `CEC_EN_RST; // [R1]
            posHyst_q <= `CEC_HYST_RST; // [R1]
            negHyst_q <= `CEC_HYST_RST; // [R1]
        end else begin
            enable_q <= enable_d;
            posHyst_q <= posHyst_d;
            negHyst_q <= negHyst_d;
        end
    end

    // ----------------------------------------------------------------
    // edge event flags
    // ----------------------------------------------------------------
    logic riseFlag_q;
    logic riseFlag_d;
    logic fallFlag_q;
    logic fallFlag_d;

    // software write first, hardware set after it: an edge that lands
    // in the same cycle as a clear is never lost
    always_comb begin
        riseFlag_d = riseFlag_q;
        fallFlag_d = fallFlag_q;
        if (ctrlWrite) begin
            riseFlag_d = sfrWdata[`CEC_BIT_RISE]; // [R3]
            fallFlag_d = sfrWdata[`CEC_BIT_FALL]; // [R4]
        end
        if (riseEvent) begin
            riseFlag_d = 1'b1; // [R3]
        end
        if (fallEvent) begin
            fallFlag_d = 1'b1; // [R4]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            riseFlag_q <= `CEC_FLAG_RST; // [R1]
            fallFlag_q <= `CEC_FLAG_RST; // [R1]
        end else begin
            riseFlag_q <= riseFlag_d;
            fallFlag_q <= fallFlag_d;
        end
    end

    // ----------------------------------------------------------------
    // mode register: interrupt enables and response mode
    // ----------------------------------------------------------------
    logic riseIe_q;
    logic riseIe_d;
    logic fallIe_q;
    logic fallIe_d;
    cec_hyst_t mode_q;
    cec_hyst_t mode_d;

    always_comb begin
        riseIe_d = riseIe_q;
        fallIe_d = fallIe_q;
        mode_d = mode_q;
        if (modeWrite) begin
            riseIe_d = sfrWdata[`CEC_BIT_RISE]; // [R7]
            fallIe_d = sfrWdata[`CEC_BIT_FALL]; // [R7]
            mode_d = sfrWdata[`CEC_MD_HI:`CEC_MD_LO];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            riseIe_q <= `CEC_IE_RST;
            fallIe_q <= `CEC_IE_RST;
            mode_q <= `CEC_MD_RST;
        end else begin
            riseIe_q <= riseIe_d;
            fallIe_q <= fallIe_d;
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------------------------------
    // read views and read mux
    // ----------------------------------------------------------------
    cec_byte_t ctrlView;
    cec_byte_t modeView;

    always_comb begin
        ctrlView = 8'h00;
        ctrlView[`CEC_BIT_EN] = enable_q; // [R2]
        ctrlView[`CEC_BIT_OUT] = syncB_q; // [R2]
        ctrlView[`CEC_BIT_RISE] = riseFlag_q; // [R3]
        ctrlView[`CEC_BIT_FALL] = fallFlag_q; // [R4]
        ctrlView[`CEC_HYP_HI:`CEC_HYP_LO] = posHyst_q; // [R5]
        ctrlView[`CEC_HYN_HI:`CEC_HYN_LO] = negHyst_q; // [R6]
    end

    // unused bits of the mode register read as zero
    always_comb begin
        modeView = 8'h00;
        modeView[`CEC_BIT_RISE] = riseIe_q;
        modeView[`CEC_BIT_FALL] = fallIe_q;
        modeView[`CEC_MD_HI:`CEC_MD_LO] = mode_q;
    end

    always_comb begin
        sfrRdata = 8'h00;
        if (ctrlHit) begin
            sfrRdata = ctrlView; // [R1]
        end else if (modeHit) begin
            sfrRdata = modeView; // [R7]
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic riseRequest;
    logic fallRequest;

    assign sfrSel = sfrRead & (ctrlHit | modeHit);
    assign compareEnable = enable_q;
    assign posHysteresisSel = posHyst_q;
    assign negHysteresisSel = negHyst_q;
    assign compareModeSel = mode_q;
    assign riseRequest = riseFlag_q & riseIe_q; // [R7]
    assign fallRequest = fallFlag_q & fallIe_q; // [R7]
    assign compareIrq = riseRequest | fallRequest;

endmodule : cec_comparator_edge_control
`default_nettype wire

// ==== dv/cec_cmp_model.sv ====
// comparator level source facing the control bank
// assumes: levelReq driven by the bench on mclk edges
`timescale 1ns/100ps
`default_nettype none
module cec_cmp_model (
    input wire logic mclk,
    input wire logic levelReq,
    output logic compareResultAsync
);
    // high while plus_input is above minus_input, settles a cycle late
    always @(posedge mclk) compareResultAsync <= levelReq;
endmodule : cec_cmp_model
`default_nettype wire

// ==== dv/cec_properties.sv ====
// port checker of the comparator control bank
// assumes: bound to cec_comparator_edge_control
`timescale 1ns/100ps
`default_nettype none
`include "cec_defs.svh"
module cec_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sfrWrite,
    input wire logic compareResultAsync,
    input wire logic compareEnable,
    input wire logic compareIrq,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    input wire logic [1:0] posHysteresisSel,
    input wire logic [1:0] negHysteresisSel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic c;
    logic [1:0] f;
    assign c = sfrAddr == `CEC_CTRL_ADDR;
    assign f = sfrRdata[5:4];
    a_en_write: assert property (sfrWrite && c |=> compareEnable == $past(sfrWdata[7]))
        else $error("enable not written");
    a_hyp_write: assert property (sfrWrite && c |=> posHysteresisSel == $past(sfrWdata[3:2]))
        else $error("pos hysteresis not written");
    a_hyn_write: assert property (sfrWrite && c |=> negHysteresisSel == $past(sfrWdata[1:0]))
        else $error("neg hysteresis not written");
    a_ctrl_readback: assert property (c |-> sfrRdata[7] == compareEnable &&
        sfrRdata[3:0] == {posHysteresisSel, negHysteresisSel}) else $error("bad readback");
    a_out_sync: assert property (c && $past(rst_n, 3)
        |-> sfrRdata[6] == $past(compareResultAsync, 2)) else $error("result bit wrong");
    a_rise_flag: assert property ($past(rst_n, 3) && $past(compareResultAsync, 2) &&
        !$past(compareResultAsync, 3) |=> !c || f[1]) else $error("rise flag missed");
    a_fall_flag: assert property ($past(rst_n, 3) && !$past(compareResultAsync, 2) &&
        $past(compareResultAsync, 3) |=> !c || f[0]) else $error("fall flag missed");
    a_flag_hold: assert property (c && !sfrWrite ##1 c |-> (f & $past(f)) == $past(f))
        else $error("flag lost");
    a_irq_quiet: assert property (c && f == 2'b00 |-> !compareIrq)
        else $error("irq without flag");
    cover property (c && f[1]);
    cover property (c && f[0]);
    cover property (compareIrq);
    cover property (sfrWrite && c && !sfrWdata[5] ##1 c && f[1]);
endmodule : cec_properties
bind cec_comparator_edge_control cec_properties i_chk (.*);
`default_nettype wire

// ==== dv/tb.sv ====
// testbench of the comparator control bank
// assumes: design, model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cec_pkg::*;
    logic mclk, rst_n, sfrWrite, sfrRead, levelReq, cra, en, irq, sel;
    cec_byte_t sfrAddr, sfrWdata, rdata;
    cec_hyst_t hyp, hyn, msel;
    int n_fail, n_checks;
    cec_byte_t rows [5][2] = '{'{8'h80, 8'h80}, '{8'h4f, 8'h0f}, '{8'h39, 8'h39},
        '{8'hc6, 8'h86}, '{8'h00, 8'h00}};
    cec_cmp_model i_cmp (.mclk(mclk), .levelReq(levelReq), .compareResultAsync(cra));
    cec_comparator_edge_control i_dut (.mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRead(sfrRead), .sfrRdata(rdata),
        .sfrSel(sel), .compareResultAsync(cra), .compareEnable(en), .posHysteresisSel(hyp),
        .negHysteresisSel(hyn), .compareModeSel(msel), .compareIrq(irq));
    task chk(input string nm, input cec_byte_t s, input cec_byte_t e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task wr(input cec_byte_t a, input cec_byte_t d);
        @(posedge mclk);
        sfrAddr <= a;
        sfrWdata <= d;
        sfrWrite <= 1'b1;
        @(posedge mclk);
        sfrWrite <= 1'b0;
    endtask : wr
    task rd(input cec_byte_t a, input cec_byte_t e);
        @(posedge mclk);
        sfrAddr <= a;
        @(negedge mclk);
        chk("rdata", rdata, e);
    endtask : rd
    task step(input logic v);
        @(posedge mclk);
        levelReq <= v;
        repeat (5) @(posedge mclk);
    endtask : step
    task test_done;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #100us;
        n_fail++;
        test_done;
    end
    initial begin
        {rst_n, sfrWrite, sfrWdata, levelReq} = '0;
        sfrRead = 1'b1;
        sfrAddr = 8'h9b;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h9b, 8'h00);
        rd(8'h9d, 8'h02);
        chk("msel", {6'h0, msel}, 8'h02);
        foreach (rows[i]) begin
            wr(8'h9b, rows[i][0]);
            rd(8'h9b, rows[i][1]);
            chk("outs", {en, 3'h0, hyp, hyn}, {rows[i][1][7], 3'h0, rows[i][1][3:0]});
        end
        $display("register rows done");
        wr(8'h9a, 8'hff);
        rd(8'h9a, 8'h00);
        rd(8'h9b, 8'h00);
        step(1'b1);
        rd(8'h9b, 8'h60);
        wr(8'h9d, 8'h20);
        rd(8'h9d, 8'h20);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(8'h9b, 8'h00);
        rd(8'h9b, 8'h40);
        chk("irq", {7'h0, irq}, 8'h00);
        step(1'b0);
        rd(8'h9b, 8'h10);
        $display("edge tests done");
        // software clear taken on the very edge that sets the rise flag
        wr(8'h9b, 8'h20);
        @(posedge mclk);
        levelReq <= 1'b1;
        repeat (2) @(posedge mclk);
        wr(8'h9b, 8'h00);
        rd(8'h9b, 8'h60);
        wr(8'h9d, 8'h13);
        rd(8'h9d, 8'h13);
        chk("msel", {6'h0, msel}, 8'h03);
        step(1'b0);
        rd(8'h9b, 8'h30);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(8'h9b, 8'h20);
        rd(8'h9b, 8'h20);
        chk("irq", {7'h0, irq}, 8'h00);
        $display("clear race and fall irq tests done");
        @(posedge mclk);
        sfrRead <= 1'b0;
        @(negedge mclk);
        chk("sel", {7'h0, sel}, 8'h00);
        @(posedge mclk);
        sfrRead <= 1'b1;
        @(negedge mclk);
        chk("sel", {7'h0, sel}, 8'h01);
        rd(8'h9a, 8'h00);
        chk("sel", {7'h0, sel}, 8'h00);
        rd(8'h9d, 8'h13);
        chk("sel", {7'h0, sel}, 8'h01);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h9b, 8'h00);
        rd(8'h9d, 8'h02);
        chk("msel", {6'h0, msel}, 8'h02);
        chk("outs", {en, 3'h0, hyp, hyn}, 8'h00);
        $display("bus select and reset tests done");
        test_done;
    end
endmodule : tb
`default_nettype wire
